// ### core/lgs_defines.svh
// Purpose: offsets, field positions and reset values of the line gain and servo bank
// Assumes: 8-bit register address, 16-bit register data
// Notes:   included by every design file that decodes or resets a field
`ifndef LGS_DEFINES_SVH
`define LGS_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define LGS_ADDR_W           8
`define LGS_DATA_W           16
`define LGS_OFS_LINE_LEFT    8'h3b
`define LGS_OFS_LINE_RIGHT   8'h3c
`define LGS_OFS_SERVO_EN     8'h43
`define LGS_OFS_SERVO_TRIG   8'h44

// ----------------------------------------------------------------------------
// line output control fields
// ----------------------------------------------------------------------------
`define LGS_BIT_SILENCE      8
`define LGS_BIT_APPLY        7
`define LGS_BIT_ZC           6
`define LGS_GAIN_W           6
`define LGS_GAIN_RST         6'h39
`define LGS_SILENCE_RST      1'h0
`define LGS_ZC_RST           1'h0

// ----------------------------------------------------------------------------
// servo fields: channel 0 left phones, 1 right phones, 2 left line, 3 right line
// ----------------------------------------------------------------------------
`define LGS_CHANS            4
`define LGS_EN_RST           4'h0
`define LGS_TRIG_ONESHOT_LSB 12
`define LGS_TRIG_BURST_LSB   8
`define LGS_TRIG_POWERUP_LSB 4
`define LGS_TRIG_VALUE_LSB   0
`define LGS_MODE_ONESHOT     3
`define LGS_MODE_BURST       2
`define LGS_MODE_POWERUP     1
`define LGS_MODE_VALUE       0

`endif

// ### core/lgs_pkg.sv
// Purpose: shared types of the line gain and servo bank
// Assumes: lgs_defines.svh holds every number
// Notes:   one-hot state codes are written out
`include "lgs_defines.svh"
package lgs_pkg;
  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef logic [`LGS_GAIN_W-1:0] lgs_gain_t;
  typedef logic [3:0]             lgs_mode_t;   // one bit per correction mode
  typedef enum logic [1:0] {
    LGS_IDLE = 2'b01,
    LGS_RUN  = 2'b10
  } lgs_state_e;
endpackage

// ### core/lgs_gain_apply.sv
// Purpose: moves a pending line gain to the active gain, optionally at a zero cross
// Assumes: apply and zero_cross are one-cycle pulses on sys_clk
// Notes:   leaving zero-cross mode while waiting applies the held gain at once
`timescale 1ns/1ps
`include "lgs_defines.svh"
module lgs_gain_apply
  import lgs_pkg::*;
(
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst,
  // control
  input  wire lgs_gain_t pend_gain,
  input  wire logic      apply,
  input  wire logic      zc_en,
  input  wire logic      zero_cross,
  // result
  output lgs_gain_t      active_gain_r,
  output logic           wait_r
);
  lgs_gain_t held_r;

  // ----------------------------------------------------------------------------
  // gain transfer
  // ----------------------------------------------------------------------------
  // immediate transfer, or hold until the next zero cross
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_gain_r <= `LGS_GAIN_RST;
      held_r        <= `LGS_GAIN_RST;
      wait_r        <= 1'b0;
    end else if (apply && !zc_en) begin
      active_gain_r <= pend_gain;
      wait_r        <= 1'b0;
    end else if (apply) begin
      held_r        <= pend_gain;
      wait_r        <= 1'b1;
    end else if (wait_r && (zero_cross || !zc_en)) begin
      active_gain_r <= held_r;
      wait_r        <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // gain never moves while a zero-cross wait is open in zero-cross mode and no crossing or apply comes
  zc_hold_gain_a: assert property (wait_r && !zero_cross && zc_en && !apply |=>
    $stable(active_gain_r)) else $error("gain moved before zero cross");
endmodule

// ### core/lgs_servo_chan.sv
// Purpose: one channel of the offset servo sequencer
// Assumes: done is a one-cycle pulse from the analogue servo loop
// Notes:   one correction at a time; triggers while busy are dropped
`timescale 1ns/1ps
`include "lgs_defines.svh"
module lgs_servo_chan
  import lgs_pkg::*;
(
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst,
  // register side
  input  wire lgs_mode_t go,
  input  wire logic      chan_en,
  // servo loop side
  input  wire logic      done,
  output logic           start_r,
  output lgs_mode_t      busy_r
);
  lgs_state_e state_r;
  lgs_mode_t  pick;

  // ----------------------------------------------------------------------------
  // mode pick: one-shot over burst over power-up over value write
  // ----------------------------------------------------------------------------
  always_comb begin
    pick = 4'h0;
    if (go[`LGS_MODE_ONESHOT])      pick[`LGS_MODE_ONESHOT] = 1'b1;
    else if (go[`LGS_MODE_BURST])   pick[`LGS_MODE_BURST]   = 1'b1;
    else if (go[`LGS_MODE_POWERUP]) pick[`LGS_MODE_POWERUP] = 1'b1;
    else if (go[`LGS_MODE_VALUE])   pick[`LGS_MODE_VALUE]   = 1'b1;
  end

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  // busy bit set on launch, cleared only by the loop's done
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= LGS_IDLE;
      busy_r  <= 4'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      unique case (state_r)
        LGS_IDLE: begin
          if (chan_en && (|go)) begin
            state_r <= LGS_RUN;
            busy_r  <= pick;
            start_r <= 1'b1;
          end
        end
        LGS_RUN: begin
          if (done) begin
            state_r <= LGS_IDLE;
            busy_r  <= 4'h0;
          end
        end
        default: begin
          state_r <= LGS_IDLE;
          busy_r  <= 4'h0;
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence running_s;
    (state_r == LGS_RUN) && !done;
  endsequence

  // a running correction keeps its flag until done, whatever is written
  busy_holds_a: assert property (running_s |=> $stable(busy_r) && (|busy_r))
    else $error("busy flag changed before done");
  done_clears_a: assert property ((state_r == LGS_RUN) && done |=> busy_r == 4'h0 ##1
    !start_r) else $error("busy flag not cleared by done");
endmodule

// ### core/lgs_bank.sv
// Function
// - Bit 8 of each line register silences that channel independently.
// - Bit 7 written as 1 moves both pending line gains to active together.
// - Bit 6 gates that channel's gain change to a zero cross.
// - Six-bit gain code: 0 is -57 dB, 1 dB steps, 0x39 is 0 dB.
// - Enable register bits 3..0: right line, left line, right phones, left phones.
// - Trigger bits 15..12 launch one correction on channels 3..0.
// - One-shot trigger bit reads 1 while that correction runs.
// - Trigger bits 11..8 launch a correction series on channels 3..0.
// - Series trigger bit reads 1 while that series is in progress.
// - Bits 7 and 6 start power-up servo on right and left line.
// - Power-up trigger bit reads 1 while its correction is in progress.
// - Bits 5 and 4 start power-up servo on right and left phones.
// - Bits 3..0 start direct offset-value write on channels 3..0.
//
// Purpose: register bank for line output gain and offset servo control
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   triggers on a disabled or busy channel are ignored
`timescale 1ns/1ps
`include "lgs_defines.svh"
module lgs_bank
  import lgs_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // register port
  input  wire logic [`LGS_ADDR_W-1:0] reg_addr,
  input  wire logic [`LGS_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`LGS_DATA_W-1:0] reg_rdata,
  // line output analogue controls
  input  wire logic                   left_line_zero_cross,
  input  wire logic                   right_line_zero_cross,
  output logic                        left_line_silence,
  output logic                        right_line_silence,
  output logic                        left_line_zero_cross_en,
  output logic                        right_line_zero_cross_en,
  output lgs_gain_t                   left_line_gain,
  output lgs_gain_t                   right_line_gain,
  // offset servo loop, one bit per channel
  input  wire logic [3:0]             servo_done,
  output logic      [3:0]             servo_en,
  output logic      [3:0]             servo_start,
  output logic      [3:0]             servo_oneshot_go,
  output logic      [3:0]             servo_burst_go,
  output logic      [3:0]             servo_powerup_go,
  output logic      [3:0]             servo_value_write_go
);
  // ----------------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------------
  logic                   left_sil_r;
  logic                   right_sil_r;
  logic                   left_zc_r;
  logic                   right_zc_r;
  lgs_gain_t              left_pend_r;
  lgs_gain_t              right_pend_r;
  logic [3:0]             servo_en_r;
  logic [`LGS_DATA_W-1:0] rdata_r;
  logic [`LGS_DATA_W-1:0] rdata_nxt;
  logic                   wr_left;
  logic                   wr_right;
  logic                   wr_trig;
  logic                   gain_apply;
  logic                   left_wait;
  logic                   right_wait;
  logic [`LGS_DATA_W-1:0] trig_view;
  lgs_mode_t              busy [`LGS_CHANS];

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  // write selects per register and the shared gain apply strobe
  assign wr_left    = reg_wr && (reg_addr == `LGS_OFS_LINE_LEFT);
  assign wr_right   = reg_wr && (reg_addr == `LGS_OFS_LINE_RIGHT);
  assign wr_trig    = reg_wr && (reg_addr == `LGS_OFS_SERVO_TRIG);
  assign gain_apply = (wr_left || wr_right) && reg_wdata[`LGS_BIT_APPLY];

  // ----------------------------------------------------------------------------
  // line output control registers
  // ----------------------------------------------------------------------------
  // left line silence, zero-cross enable and pending gain
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      left_sil_r  <= `LGS_SILENCE_RST;
      left_zc_r   <= `LGS_ZC_RST;
      left_pend_r <= `LGS_GAIN_RST;
    end else if (wr_left) begin
      left_sil_r  <= reg_wdata[`LGS_BIT_SILENCE];
      left_zc_r   <= reg_wdata[`LGS_BIT_ZC];
      left_pend_r <= reg_wdata[`LGS_GAIN_W-1:0];
    end
  end

  // right line silence, zero-cross enable and pending gain
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      right_sil_r  <= `LGS_SILENCE_RST;
      right_zc_r   <= `LGS_ZC_RST;
      right_pend_r <= `LGS_GAIN_RST;
    end else if (wr_right) begin
      right_sil_r  <= reg_wdata[`LGS_BIT_SILENCE];
      right_zc_r   <= reg_wdata[`LGS_BIT_ZC];
      right_pend_r <= reg_wdata[`LGS_GAIN_W-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // gain transfer, one per line channel
  // ----------------------------------------------------------------------------
  // the pending value seen is the one being written when that register is hit
  lgs_gain_apply u_left_gain (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .pend_gain     (wr_left ? reg_wdata[`LGS_GAIN_W-1:0] : left_pend_r),
    .apply         (gain_apply),
    .zc_en         (wr_left ? reg_wdata[`LGS_BIT_ZC] : left_zc_r),
    .zero_cross    (left_line_zero_cross),
    .active_gain_r (left_line_gain),
    .wait_r        (left_wait)
  );

  lgs_gain_apply u_right_gain (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .pend_gain     (wr_right ? reg_wdata[`LGS_GAIN_W-1:0] : right_pend_r),
    .apply         (gain_apply),
    .zc_en         (wr_right ? reg_wdata[`LGS_BIT_ZC] : right_zc_r),
    .zero_cross    (right_line_zero_cross),
    .active_gain_r (right_line_gain),
    .wait_r        (right_wait)
  );

  // ----------------------------------------------------------------------------
  // servo enable register
  // ----------------------------------------------------------------------------
  // bit i enables servo channel i
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      servo_en_r <= `LGS_EN_RST;
    end else if (reg_wr && (reg_addr == `LGS_OFS_SERVO_EN)) begin
      servo_en_r <= reg_wdata[`LGS_CHANS-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // servo channels
  // ----------------------------------------------------------------------------
  // each channel takes its four trigger bits from the trigger write
  for (genvar i = 0; i < `LGS_CHANS; i++) begin : g_chan
    lgs_mode_t go;
    always_comb begin
      go = 4'h0;
      if (wr_trig) begin
        go[`LGS_MODE_ONESHOT] = reg_wdata[`LGS_TRIG_ONESHOT_LSB+i];
        go[`LGS_MODE_BURST]   = reg_wdata[`LGS_TRIG_BURST_LSB+i];
        go[`LGS_MODE_POWERUP] = reg_wdata[`LGS_TRIG_POWERUP_LSB+i];
        go[`LGS_MODE_VALUE]   = reg_wdata[`LGS_TRIG_VALUE_LSB+i];
      end
    end

    lgs_servo_chan u_chan (
      .sys_clk (sys_clk),
      .rst     (rst),
      .go      (go),
      .chan_en (servo_en_r[i]),
      .done    (servo_done[i]),
      .start_r (servo_start[i]),
      .busy_r  (busy[i])
    );

    // in-progress flags gathered into the trigger register view
    assign servo_oneshot_go[i]     = busy[i][`LGS_MODE_ONESHOT];
    assign servo_burst_go[i]       = busy[i][`LGS_MODE_BURST];
    assign servo_powerup_go[i]     = busy[i][`LGS_MODE_POWERUP];
    assign servo_value_write_go[i] = busy[i][`LGS_MODE_VALUE];
  end

  // trigger register readback shows work in progress
  assign trig_view = {servo_oneshot_go, servo_burst_go,
                      servo_powerup_go, servo_value_write_go};

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  // apply strobe bit reads as zero; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `LGS_OFS_LINE_LEFT:  rdata_nxt = {7'h00, left_sil_r, 1'b0, left_zc_r, left_pend_r};
        `LGS_OFS_LINE_RIGHT: rdata_nxt = {7'h00, right_sil_r, 1'b0, right_zc_r, right_pend_r};
        `LGS_OFS_SERVO_EN:   rdata_nxt = {12'h000, servo_en_r};
        `LGS_OFS_SERVO_TRIG: rdata_nxt = trig_view;
        default:             rdata_nxt = 16'h0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign reg_rdata                = rdata_r;
  assign left_line_silence        = left_sil_r;
  assign right_line_silence       = right_sil_r;
  assign left_line_zero_cross_en  = left_zc_r;
  assign right_line_zero_cross_en = right_zc_r;
  assign servo_en                 = servo_en_r;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence trig_write_s(int b, int ch);
    wr_trig && reg_wdata == (16'h0001 << b) && servo_en_r[ch] && busy[ch] == 4'h0;
  endsequence

  silence_follows_a: assert property (wr_left |=>
    left_line_silence == $past(reg_wdata[`LGS_BIT_SILENCE]) && $stable(right_line_silence))
    else $error("left silence not taken from write");
  gain_together_a: assert property (wr_left && reg_wdata[`LGS_BIT_APPLY]
    && !reg_wdata[`LGS_BIT_ZC] && !right_zc_r |=> left_line_gain == $past(reg_wdata[5:0])
    && right_line_gain == $past(right_pend_r)) else $error("gains not applied together");
  zc_defers_a: assert property (wr_right && reg_wdata[`LGS_BIT_APPLY]
    && reg_wdata[`LGS_BIT_ZC] && !right_line_zero_cross |=> right_wait)
    else $error("zero-cross gain change not deferred");
  gain_readback_a: assert property (reg_rd && reg_addr == `LGS_OFS_LINE_LEFT |=>
    reg_rdata[5:0] == $past(left_pend_r) && reg_rdata[7] == 1'b0)
    else $error("pending gain readback wrong");
  enable_read_a: assert property (reg_rd && reg_addr == `LGS_OFS_SERVO_EN |=>
    reg_rdata == {12'h000, $past(servo_en_r)}) else $error("enable readback wrong");
  oneshot_launch_a: assert property (trig_write_s(`LGS_TRIG_ONESHOT_LSB + 3, 3) |=>
    servo_oneshot_go[3] && servo_start[3] ##1 !servo_start[3])
    else $error("one-shot not launched");
  burst_launch_a: assert property (trig_write_s(`LGS_TRIG_BURST_LSB + 2, 2) |=>
    servo_burst_go[2] && servo_start[2]) else $error("series not launched");
  powerup_launch_a: assert property (trig_write_s(`LGS_TRIG_POWERUP_LSB + 1, 1) |=>
    servo_powerup_go[1] && servo_start[1]) else $error("power-up not launched");
  line_powerup_a: assert property (trig_write_s(`LGS_TRIG_POWERUP_LSB + 3, 3) |=>
    servo_powerup_go[3]) else $error("line power-up not launched");
  value_launch_a: assert property (trig_write_s(`LGS_TRIG_VALUE_LSB, 0) |=>
    servo_value_write_go[0]) else $error("value write not launched");
  trig_readback_a: assert property (reg_rd && reg_addr == `LGS_OFS_SERVO_TRIG |=>
    reg_rdata == $past(trig_view)) else $error("trigger readback not in-progress view");
  disabled_ignored_a: assert property (wr_trig && servo_en_r == 4'h0
    && servo_start == 4'h0 && trig_view == 16'h0000 |=> trig_view == 16'h0000)
    else $error("trigger taken on disabled channel");

  // right silence from its own write only
  right_silence_a: assert property (wr_right |=>
    right_line_silence == $past(reg_wdata[`LGS_BIT_SILENCE]) && $stable(left_line_silence))
    else $error("right silence not taken");

  // a right apply moves both gains together
  right_together_a: assert property (wr_right && reg_wdata[`LGS_BIT_APPLY]
    && !reg_wdata[`LGS_BIT_ZC] && !left_zc_r |=> right_line_gain == $past(reg_wdata[5:0])
    && left_line_gain == $past(left_pend_r)) else $error("gains not moved together");

  // gains move only on an apply or a closing wait
  gain_still_a: assert property (!gain_apply && !left_wait && !right_wait |=>
    $stable(left_line_gain) && $stable(right_line_gain)) else $error("gain moved unasked");

  // the right apply opens the left zero-cross wait
  left_defers_a: assert property (wr_right && reg_wdata[`LGS_BIT_APPLY] && left_zc_r
    |=> left_wait) else $error("left change not deferred");

  // a crossing closes the wait
  zc_release_a: assert property (left_wait && left_line_zero_cross && !gain_apply |=>
    !left_wait) else $error("left wait not closed");

  // right readback fields
  right_readback_a: assert property (reg_rd && reg_addr == `LGS_OFS_LINE_RIGHT |=>
    reg_rdata == {7'h00, $past(right_sil_r), 1'b0, $past(right_zc_r), $past(right_pend_r)})
    else $error("right readback wrong");

  // enable taken from the low write bits
  enable_write_a: assert property (reg_wr && reg_addr == `LGS_OFS_SERVO_EN |=>
    servo_en == $past(reg_wdata[3:0])) else $error("enable not taken");

  // left line power-up, right line value write
  left_powerup_a: assert property (trig_write_s(`LGS_TRIG_POWERUP_LSB + 2, 2) |=>
    servo_powerup_go[2]) else $error("left power-up not launched");
  right_value_a: assert property (trig_write_s(`LGS_TRIG_VALUE_LSB + 3, 3) |=>
    servo_value_write_go[3]) else $error("right value write not launched");

  // busy channel refuses a launch
  busy_refused_a: assert property (wr_trig && (|busy[3]) |=> !servo_start[3])
    else $error("launch taken while busy");

  // a zero write moves no flag
  zero_write_a: assert property (wr_trig && reg_wdata == 16'h0000 && servo_done == 4'h0
    |=> $stable(trig_view)) else $error("zero write moved a flag");
endmodule

// ### dv/lgs_bank_tb_top.sv
// Purpose: self-checking bench for the line gain and offset servo register bank
// Assumes: read data stands in the cycle after the read strobe; outputs settle one edge on
// Notes:   zero-cross and servo done pulses are made by the bench itself
`timescale 1ns/1ps
`include "lgs_defines.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module lgs_bank_tb_top;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic               sys_clk;
  logic               rst;
  logic [7:0]         reg_addr;
  logic [15:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [15:0]        reg_rdata;
  logic               left_zc;
  logic               right_zc;
  logic               left_line_silence;
  logic               right_line_silence;
  logic               left_line_zero_cross_en;
  logic               right_line_zero_cross_en;
  lgs_pkg::lgs_gain_t left_line_gain;
  lgs_pkg::lgs_gain_t right_line_gain;
  logic [3:0]         servo_done;
  logic [3:0]         servo_en;
  logic [3:0]         servo_start;
  logic [3:0]         servo_oneshot_go;
  logic [3:0]         servo_burst_go;
  logic [3:0]         servo_powerup_go;
  logic [3:0]         servo_value_write_go;
  logic [15:0]        busy_all;
  int                 n_errors;
  int                 checks_done;

  // busy flags laid out like the trigger register
  assign busy_all = {servo_oneshot_go, servo_burst_go, servo_powerup_go, servo_value_write_go};

  lgs_bank dut (
    .sys_clk                 (sys_clk),
    .rst                     (rst),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .left_line_zero_cross    (left_zc),
    .right_line_zero_cross   (right_zc),
    .left_line_silence       (left_line_silence),
    .right_line_silence      (right_line_silence),
    .left_line_zero_cross_en (left_line_zero_cross_en),
    .right_line_zero_cross_en(right_line_zero_cross_en),
    .left_line_gain          (left_line_gain),
    .right_line_gain         (right_line_gain),
    .servo_done              (servo_done),
    .servo_en                (servo_en),
    .servo_start             (servo_start),
    .servo_oneshot_go        (servo_oneshot_go),
    .servo_burst_go          (servo_burst_go),
    .servo_powerup_go        (servo_powerup_go),
    .servo_value_write_go    (servo_value_write_go)
  );

  // --------------------------------------------------------------------------
  // bus and pulse tasks
  // --------------------------------------------------------------------------
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // one-cycle write; returns once the taking edge has landed
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // one-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // one-cycle pulse on {right zero cross, left zero cross, servo done}
  task automatic pulse(input logic [5:0] v);
    @(posedge sys_clk);
    {right_zc, left_zc, servo_done} <= v;
    @(posedge sys_clk);
    {right_zc, left_zc, servo_done} <= 6'h00;
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  // reset values, unmapped read
  task automatic t_reset();
    logic [15:0] d;
    rd(`LGS_OFS_LINE_LEFT, d);
    `CHK(d, 16'h0039)
    rd(`LGS_OFS_SERVO_EN, d);
    `CHK(d, 16'h0000)
    rd(`LGS_OFS_SERVO_TRIG, d);
    `CHK(d, 16'h0000)
    rd(8'h00, d);
    `CHK(d, 16'h0000)
    `CHK({left_line_gain, right_line_gain, left_line_silence}, {6'h39, 6'h39, 1'b0})
    $display("test reset done");
  endtask

  // silence per channel, joint apply, readback without the apply bit
  task automatic t_gain();
    logic [15:0] d;
    wr(`LGS_OFS_LINE_LEFT, 16'h0105);
    `CHK({left_line_silence, right_line_silence, left_line_gain}, {2'b10, 6'h39})
    wr(`LGS_OFS_LINE_RIGHT, 16'h0088);
    `CHK({left_line_gain, right_line_gain}, {6'h05, 6'h08})
    rd(`LGS_OFS_LINE_LEFT, d);
    `CHK(d, 16'h0105)
    rd(`LGS_OFS_LINE_RIGHT, d);
    `CHK(d, 16'h0008)
    wr(`LGS_OFS_LINE_LEFT, 16'h0087);
    `CHK({left_line_gain, right_line_gain}, {6'h07, 6'h08})
    $display("test gain done");
  endtask

  // zero-cross gating on both channels, extreme gain codes
  task automatic t_zc();
    wr(`LGS_OFS_LINE_LEFT, 16'h0040);
    wr(`LGS_OFS_LINE_RIGHT, 16'h00ff);
    `CHK({left_line_zero_cross_en, right_line_zero_cross_en}, 2'b11)
    `CHK({left_line_gain, right_line_gain}, {6'h07, 6'h08})
    pulse(6'h10);
    `CHK({left_line_gain, right_line_gain}, {6'h00, 6'h08})
    pulse(6'h20);
    `CHK({left_line_gain, right_line_gain}, {6'h00, 6'h3f})
    wr(`LGS_OFS_LINE_LEFT, 16'h0000);
    wr(`LGS_OFS_LINE_RIGHT, 16'h0000);
    `CHK({left_line_zero_cross_en, right_line_zero_cross_en}, 2'b00)
    $display("test zero cross done");
  endtask

  // triggers on disabled channels dropped, priority on one enabled channel
  task automatic t_servo_off();
    wr(`LGS_OFS_SERVO_TRIG, 16'hffff);
    `CHK({servo_start, busy_all}, 20'h00000)
    wr(`LGS_OFS_SERVO_EN, 16'h0008);
    `CHK(servo_en, 4'h8)
    wr(`LGS_OFS_SERVO_TRIG, 16'hffff);
    `CHK({servo_start, busy_all}, {4'h8, 16'h8000})
    pulse(6'h08);
    `CHK(busy_all, 16'h0000)
    $display("test servo disabled done");
  endtask

  // every mode on every channel: start, busy, refusal, zero write, self-clear
  task automatic t_servo_modes();
    logic [15:0] d;
    int          c;
    wr(`LGS_OFS_SERVO_EN, 16'h000f);
    rd(`LGS_OFS_SERVO_EN, d);
    `CHK(d, 16'h000f)
    for (int b = 0; b < 16; b++) begin
      c = b % 4;
      wr(`LGS_OFS_SERVO_TRIG, 16'h0001 << b);
      `CHK({servo_start, busy_all}, {4'h1 << c, 16'h0001 << b})
      wr(`LGS_OFS_SERVO_TRIG, 16'h1111 << c);
      `CHK({servo_start, busy_all}, {4'h0, 16'h0001 << b})
      wr(`LGS_OFS_SERVO_TRIG, 16'h0000);
      rd(`LGS_OFS_SERVO_TRIG, d);
      `CHK(d, 16'h0001 << b)
      pulse(6'h01 << c);
      rd(`LGS_OFS_SERVO_TRIG, d);
      `CHK(d, 16'h0000)
    end
    $display("test servo modes done");
  endtask

  // --------------------------------------------------------------------------
  // main sequence and hang guard
  // --------------------------------------------------------------------------
  initial begin
    n_errors    = 0;
    checks_done = 0;
    rst         = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    left_zc     = 1'b0;
    right_zc    = 1'b0;
    servo_done  = 4'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_gain();
    t_zc();
    t_servo_off();
    t_servo_modes();
    report_and_stop();
  end

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule
